//--- hw/pcrr_top.sv
`timescale 1ns/1ns
module pcrr_buf2 #(
  parameter int unsigned WIDTH = 8
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  logic [WIDTH-1:0] skid_q;
  logic skid_vld_q;
  logic push;
  logic pop;

  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Head register plus one skid slot; ready is registered so it is honest
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      out_valid_o <= 1'b0;
      out_data_o <= '0;
      skid_q <= '0;
      skid_vld_q <= 1'b0;
      in_ready_o <= 1'b1;
    end else begin
      if (pop || !out_valid_o) begin
        out_valid_o <= skid_vld_q || push;
        out_data_o <= skid_vld_q ? skid_q : in_data_i;
        if (skid_vld_q && push) begin
          skid_q <= in_data_i;
        end
        skid_vld_q <= skid_vld_q && push;
        in_ready_o <= 1'b1;
      end else if (push) begin
        skid_q <= in_data_i;
        skid_vld_q <= 1'b1;
        in_ready_o <= 1'b0; // Both slots full
      end
    end
  end
endmodule : pcrr_buf2

module pcrr_top
  import pcrr_pkg::*;
#(
  parameter int unsigned ENTRIES = MAP_ENTRIES,
  parameter int unsigned SLOTS = BLOCK_SLOTS
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Global configuration
  input wire logic can_report_enable_i,
  input wire logic [ID_W-1:0] report_id_origin_i,
  input wire logic cfg_time_load_i,
  input wire logic [TIME_W-1:0] report_period_i,
  input wire logic [TIME_W-1:0] inter_message_gap_i,
  input wire logic [TIME_W-1:0] err_window_i,
  // Individual entry configuration
  input wire logic entry_wr_i,
  input wire logic [5:0] entry_idx_i,
  input wire logic [ADDR_W-1:0] entry_source_pointer_i,
  input wire logic entry_direction_select_i,
  // Block slot configuration
  input wire logic slot_wr_i,
  input wire logic [1:0] slot_idx_i,
  input wire logic [ADDR_W-1:0] slot_base_i,
  input wire logic [ADDR_W-1:0] slot_stride_i,
  input wire logic [CNT_W-1:0] slot_count_i,
  // Internal register space
  output logic reg_rd_req_o,
  output logic [ADDR_W-1:0] reg_rd_addr_o,
  input wire logic reg_rd_valid_i,
  input wire logic [DATA_W-1:0] reg_rd_data_i,
  output logic reg_wr_o,
  output logic [ADDR_W-1:0] reg_wr_addr_o,
  output logic [DATA_W-1:0] reg_wr_data_o,
  // CAN frame stream
  output logic tx_valid_o,
  input wire logic tx_ready_i,
  output pcrr_frame_s tx_frame_o,
  input wire logic rx_valid_i,
  input wire pcrr_frame_s rx_frame_i,
  input wire logic bus_err_i,
  // Status
  input wire logic [2:0] conn_state_i,
  output pcrr_conn_e conn_state_o,
  output logic [TIME_W-1:0] err_rate_o,
  output logic scan_busy_o
);
  if (ENTRIES < 1 || ENTRIES > MAP_ENTRIES || SLOTS < 1 || SLOTS > BLOCK_SLOTS) begin : g_chk
    $error("pcrr_top: ENTRIES or SLOTS out of range");
  end

  typedef enum logic [2:0] {ST_IDLE, ST_SCAN, ST_READ, ST_PUSH, ST_GAP} pcrr_state_e;

  localparam logic [7:0] PRE_MAX = 8'(CYC_PER_UNIT - 1);

  pcrr_state_e state_q;
  logic [ADDR_W-1:0] ptr_q [ENTRIES];
  logic dir_q [ENTRIES];
  logic [ADDR_W-1:0] sbase_q [SLOTS];
  logic [ADDR_W-1:0] sstride_q [SLOTS];
  logic [CNT_W-1:0] scount_q [SLOTS];
  logic [TIME_W-1:0] period_q, gap_q, window_q;
  logic [7:0] pre_q;
  logic tick;
  logic [TIME_W-1:0] per_cnt_q, gap_cnt_q, win_cnt_q, err_cnt_q;
  logic start_q;
  logic [6:0] idx_q;
  logic in_blocks_q;
  logic [2:0] slot_q;
  logic [CNT_W-1:0] elem_q;
  logic [ADDR_W-1:0] baddr_q;
  logic [ID_W-1:0] bid_q;
  pcrr_frame_s frame_q;
  logic buf_ready;
  logic [6:0] rx_rel;

  assign tick = (pre_q == PRE_MAX);

  // Configuration storage; all entries disabled out of reset
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < ENTRIES; i++) begin
        ptr_q[i] <= PTR_DISABLED;
        dir_q[i] <= 1'b0;
      end
      for (int s = 0; s < SLOTS; s++) begin
        sbase_q[s] <= PTR_DISABLED;
        sstride_q[s] <= '0;
        scount_q[s] <= '0;
      end
      period_q <= RST_REPORT_PERIOD;
      gap_q <= RST_GAP;
      window_q <= RST_ERR_WINDOW;
    end else begin
      if (entry_wr_i && 32'(entry_idx_i) < ENTRIES) begin
        ptr_q[entry_idx_i] <= entry_source_pointer_i;
        dir_q[entry_idx_i] <= entry_direction_select_i;
      end
      if (slot_wr_i && 32'(slot_idx_i) < SLOTS) begin
        sbase_q[slot_idx_i] <= slot_base_i;
        sstride_q[slot_idx_i] <= slot_stride_i;
        scount_q[slot_idx_i] <= slot_count_i;
      end
      if (cfg_time_load_i) begin
        period_q <= report_period_i;
        gap_q <= inter_message_gap_i;
        window_q <= err_window_i;
      end
    end
  end

  // Microsecond prescaler keeps the long counters narrow
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pre_q <= '0;
    end else begin
      pre_q <= tick ? 8'h00 : pre_q + 8'h01;
    end
  end

  // Period timer; a pending start survives a scan that overruns the period
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      per_cnt_q <= '0;
      start_q <= 1'b0;
    end else begin
      if (tick) begin
        per_cnt_q <= (per_cnt_q + 24'h000001 >= period_q) ? 24'h000000 : per_cnt_q + 24'h000001;
      end
      if (tick && per_cnt_q + 24'h000001 >= period_q) begin
        start_q <= 1'b1; // set wins over the take below
      end else if (state_q == ST_IDLE && can_report_enable_i) begin
        start_q <= 1'b0;
      end
    end
  end

  // Error rate: errors counted per window, latched at window end
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      win_cnt_q <= '0;
      err_cnt_q <= '0;
      err_rate_o <= '0;
    end else begin
      if (tick && win_cnt_q + 24'h000001 >= window_q) begin
        win_cnt_q <= '0;
        err_rate_o <= err_cnt_q + {23'h000000, bus_err_i};
        err_cnt_q <= '0;
      end else begin
        if (tick) begin
          win_cnt_q <= win_cnt_q + 24'h000001;
        end
        if (bus_err_i && err_cnt_q != 24'hFFFFFF) begin
          err_cnt_q <= err_cnt_q + 24'h000001;
        end
      end
    end
  end

  // Report scan sequencer
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= ST_IDLE;
      idx_q <= '0;
      in_blocks_q <= 1'b0;
      slot_q <= '0;
      elem_q <= '0;
      baddr_q <= '0;
      bid_q <= '0;
      frame_q <= '0;
      gap_cnt_q <= '0;
      reg_rd_req_o <= 1'b0;
      reg_rd_addr_o <= '0;
      scan_busy_o <= 1'b0;
    end else begin
      reg_rd_req_o <= 1'b0;
      unique case (state_q)
        ST_IDLE: begin
          if (start_q && can_report_enable_i) begin
            state_q <= ST_SCAN;
            idx_q <= '0;
            in_blocks_q <= 1'b0;
            slot_q <= '0;
            elem_q <= '0;
            bid_q <= '0;
            baddr_q <= sbase_q[0];
            scan_busy_o <= 1'b1;
          end
        end
        ST_SCAN: begin
          if (!can_report_enable_i) begin
            state_q <= ST_IDLE;
            scan_busy_o <= 1'b0;
          end else if (!in_blocks_q) begin
            if (32'(idx_q) >= ENTRIES) begin
              in_blocks_q <= 1'b1;
            end else begin
              if (ptr_q[idx_q[5:0]] != PTR_DISABLED && !dir_q[idx_q[5:0]]) begin
                reg_rd_req_o <= 1'b1;
                reg_rd_addr_o <= ptr_q[idx_q[5:0]];
                frame_q.id <= report_id_origin_i + ID_W'(idx_q);
                state_q <= ST_READ;
              end
              idx_q <= idx_q + 7'h01;
            end
          end else if (32'(slot_q) >= SLOTS) begin
            state_q <= ST_IDLE;
            scan_busy_o <= 1'b0;
          end else if (elem_q >= scount_q[slot_q[1:0]]) begin
            slot_q <= slot_q + 3'h1;
            elem_q <= '0;
            baddr_q <= (32'(slot_q) + 1 < SLOTS) ? sbase_q[slot_q[1:0] + 2'h1] : PTR_DISABLED;
          end else begin
            // Disabled slots still consume their identifiers
            if (sbase_q[slot_q[1:0]] != PTR_DISABLED) begin
              reg_rd_req_o <= 1'b1;
              reg_rd_addr_o <= baddr_q;
              frame_q.id <= report_id_origin_i + BLOCK_ID_OFFSET + bid_q;
              state_q <= ST_READ;
            end
            elem_q <= elem_q + 8'h01;
            bid_q <= bid_q + 11'h001;
            baddr_q <= baddr_q + sstride_q[slot_q[1:0]];
          end
        end
        ST_READ: begin
          if (reg_rd_valid_i) begin
            frame_q.data <= reg_rd_data_i;
            state_q <= ST_PUSH;
          end
        end
        ST_PUSH: begin
          if (buf_ready) begin
            gap_cnt_q <= '0;
            state_q <= (gap_q == '0) ? ST_SCAN : ST_GAP;
          end
        end
        ST_GAP: begin
          // Gap counted in whole microsecond ticks
          if (tick) begin
            gap_cnt_q <= gap_cnt_q + 24'h000001;
            if (gap_cnt_q + 24'h000001 >= gap_q) begin
              state_q <= ST_SCAN;
            end
          end
        end
      endcase
    end
  end

  // Two-entry buffer so a stalled transmitter loses no report
  pcrr_buf2 #(
    .WIDTH($bits(pcrr_frame_s))
  ) u_txbuf (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .in_valid_i(state_q == ST_PUSH),
    .in_ready_o(buf_ready),
    .in_data_i(frame_q),
    .out_valid_o(tx_valid_o),
    .out_ready_i(tx_ready_i),
    .out_data_o(tx_frame_o)
  );

  assign rx_rel = 7'(rx_frame_i.id - report_id_origin_i);

  // Command frames; only ids inside the individual range can match
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_wr_o <= 1'b0;
      reg_wr_addr_o <= '0;
      reg_wr_data_o <= '0;
    end else begin
      reg_wr_o <= 1'b0;
      if (rx_valid_i && ID_W'(rx_frame_i.id - report_id_origin_i) < ID_W'(ENTRIES)
          && ptr_q[rx_rel[5:0]] != PTR_DISABLED && dir_q[rx_rel[5:0]]) begin
        reg_wr_o <= 1'b1;
        reg_wr_addr_o <= ptr_q[rx_rel[5:0]];
        reg_wr_data_o <= rx_frame_i.data;
      end
    end
  end

  // Connection state, illegal codes shown as disconnected
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      conn_state_o <= PCRR_DISCONNECTED;
    end else begin
      conn_state_o <= (conn_state_i > 3'h4) ? PCRR_DISCONNECTED : pcrr_conn_e'(conn_state_i);
    end
  end
endmodule : pcrr_top

//--- pkg/pcrr_pkg.sv
package pcrr_pkg;
  // Clock and time base; configured times are in microseconds
  localparam int unsigned CLK_FREQ_HZ = 50_000_000;
  localparam int unsigned TIME_UNIT_NS = 1000;
  localparam int unsigned CYC_PER_UNIT = (CLK_FREQ_HZ / 1_000_000) * TIME_UNIT_NS / 1000;
  // Widths
  localparam int unsigned ID_W = 11;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned TIME_W = 24;
  localparam int unsigned CNT_W = 8;
  // Map sizes and identifier layout
  localparam int unsigned MAP_ENTRIES = 64;
  localparam int unsigned BLOCK_SLOTS = 4;
  localparam logic [ID_W-1:0] BLOCK_ID_OFFSET = 11'h040;
  // Reset values of the configuration
  localparam logic [ID_W-1:0] RST_ID_ORIGIN = 11'h100;
  localparam logic [TIME_W-1:0] RST_REPORT_PERIOD = 24'h07A120;
  localparam logic [TIME_W-1:0] RST_GAP = 24'h0003E8;
  localparam logic [TIME_W-1:0] RST_ERR_WINDOW = 24'h2DC6C0;
  localparam logic [ADDR_W-1:0] PTR_DISABLED = 16'h0000;

  // Connection state encoding shown on conn_state_o
  typedef enum logic [2:0] {
    PCRR_DISCONNECTED = 3'h0,
    PCRR_PRECHARGE = 3'h1,
    PCRR_CONNECTING = 3'h2,
    PCRR_CONNECTED = 3'h3,
    PCRR_DISCONNECTING = 3'h4
  } pcrr_conn_e;

  // One outgoing or incoming frame
  typedef struct packed {
    logic [ID_W-1:0] id;
    logic [DATA_W-1:0] data;
  } pcrr_frame_s;
endpackage : pcrr_pkg

//--- tb/pcrr_assertions.sv
`timescale 1ns/1ns
module pcrr_chk
  import pcrr_pkg::*;
(
  // Clock, reset and bench inputs
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic can_report_enable_i,
  input wire logic [ID_W-1:0] report_id_origin_i,
  input wire logic reg_rd_valid_i,
  input wire logic rx_valid_i,
  input wire logic tx_ready_i,
  input wire logic [2:0] conn_state_i,
  // Design outputs
  input wire logic reg_rd_req_o,
  input wire logic [ADDR_W-1:0] reg_rd_addr_o,
  input wire logic reg_wr_o,
  input wire logic [ADDR_W-1:0] reg_wr_addr_o,
  input wire logic tx_valid_o,
  input wire pcrr_frame_s tx_frame_o,
  input wire logic scan_busy_o,
  input wire pcrr_conn_e conn_state_o
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  a_scan_needs_enable: assert property ($rose(scan_busy_o) |-> $past(can_report_enable_i))
    else $error("scan started while reporting was off");
  a_idle_no_read: assert property ((!can_report_enable_i) [*3] |-> !reg_rd_req_o)
    else $error("register read while reporting was off");
  a_stall_holds: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_frame_o))
    else $error("frame dropped or changed during a stall");
  a_read_nonnull: assert property (reg_rd_req_o |-> reg_rd_addr_o != PTR_DISABLED)
    else $error("read issued for a disabled pointer");
  a_write_cause: assert property (reg_wr_o |-> $past(rx_valid_i))
    else $error("register write without a received frame");
  a_write_nonnull: assert property (reg_wr_o |-> reg_wr_addr_o != PTR_DISABLED)
    else $error("write issued for a disabled pointer");
  a_conn_map: assert property ($past(reset_n_i) |->
    conn_state_o == ($past(conn_state_i) > 3'h4 ? 3'h0 : $past(conn_state_i)))
    else $error("connection state encoding wrong");
  a_id_floor: assert property (tx_valid_o |-> tx_frame_o.id >= report_id_origin_i)
    else $error("frame identifier below the origin");
  a_read_to_frame: assert property (reg_rd_valid_i |-> ##[1:10] tx_valid_o)
    else $error("read value never offered as a frame");
  // Main scenarios reached
  c_stall: cover property (tx_valid_o && !tx_ready_i);
  c_cmd_write: cover property (reg_wr_o);
  c_scan: cover property ($rose(scan_busy_o));
endmodule : pcrr_chk

//--- tb/pcrr_reg_model.sv
`timescale 1ns/1ns
module pcrr_reg_model (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Answer speed
  input wire logic slow_i,
  // Register read port
  input wire logic rd_req_i,
  input wire logic [15:0] rd_addr_i,
  output logic rd_valid_o,
  output logic [31:0] rd_data_o,
  // Frame sink
  input wire logic tx_valid_i,
  output logic tx_ready_o
);
  logic [1:0] wait_q;
  logic [1:0] stall_q;
  logic [15:0] addr_q;
  // Answer one or three cycles late; data churns between answers so stale reads show
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wait_q <= 2'h0;
      addr_q <= 16'h0000;
      rd_valid_o <= 1'b0;
      rd_data_o <= 32'h00000000;
    end else begin
      rd_valid_o <= (wait_q == 2'h1);
      rd_data_o <= (wait_q == 2'h1) ? {16'hDA7A, addr_q} : ~rd_data_o;
      if (rd_req_i) begin
        wait_q <= slow_i ? 2'h3 : 2'h1;
        addr_q <= rd_addr_i;
      end else if (wait_q != 2'h0) begin
        wait_q <= wait_q - 2'h1;
      end
    end
  end
  // When slow, every frame waits two cycles before it is taken
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stall_q <= 2'h0;
    end else if (tx_valid_i && tx_ready_o) begin
      stall_q <= 2'h0;
    end else if (tx_valid_i) begin
      stall_q <= stall_q + 2'h1;
    end
  end
  assign tx_ready_o = !slow_i || (stall_q == 2'h2);
endmodule : pcrr_reg_model

//--- tb/testbench.sv
`timescale 1ns/1ns
module testbench;
  import pcrr_pkg::*;
  // Design inputs; origin stays low enough for every id to fit
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic can_report_enable_i = 1'b0;
  logic [ID_W-1:0] report_id_origin_i = RST_ID_ORIGIN;
  logic cfg_time_load_i = 1'b0;
  logic [TIME_W-1:0] report_period_i = 24'h000032;
  logic [TIME_W-1:0] inter_message_gap_i = 24'h000002;
  logic [TIME_W-1:0] err_window_i = 24'h000014;
  logic entry_wr_i = 1'b0;
  logic [5:0] entry_idx_i = 6'h00;
  logic [ADDR_W-1:0] entry_source_pointer_i = 16'h0000;
  logic entry_direction_select_i = 1'b0;
  logic slot_wr_i = 1'b0;
  logic [1:0] slot_idx_i = 2'h0;
  logic [ADDR_W-1:0] slot_base_i = 16'h0100;
  logic [ADDR_W-1:0] slot_stride_i = 16'h0002;
  logic [CNT_W-1:0] slot_count_i = 8'h02;
  logic rx_valid_i = 1'b0;
  logic bus_err_i = 1'b0;
  logic slow = 1'b0;
  logic [2:0] conn_state_i = 3'h0;
  pcrr_frame_s rx_frame_i = '0;
  // Design outputs and model answers
  logic reg_rd_req_o, reg_rd_valid_i, reg_wr_o, tx_valid_o, tx_ready_i, scan_busy_o;
  logic [ADDR_W-1:0] reg_rd_addr_o, reg_wr_addr_o;
  logic [DATA_W-1:0] reg_rd_data_i, reg_wr_data_o;
  logic [TIME_W-1:0] err_rate_o;
  pcrr_frame_s tx_frame_o;
  pcrr_conn_e conn_state_o;
  // Bench state; rows hold {state in, state out}
  int n_errors = 0;
  int comparisons = 0;
  int cyc = 0;
  int at_q[$];
  pcrr_frame_s got_q[$];
  pcrr_frame_s exp_f[4];
  logic [47:0] wr_q[$];
  logic [5:0] conn_row[8] = '{6'h00, 6'h09, 6'h12, 6'h1B, 6'h24, 6'h28, 6'h30, 6'h38};

  always #10 clk_sys_i = ~clk_sys_i;

  pcrr_top dut_u (.*);
  pcrr_reg_model model_u (.clk_sys_i, .reset_n_i, .slow_i(slow), .rd_req_i(reg_rd_req_o),
    .rd_addr_i(reg_rd_addr_o), .rd_valid_o(reg_rd_valid_i), .rd_data_o(reg_rd_data_i),
    .tx_valid_i(tx_valid_o), .tx_ready_o(tx_ready_i));

  // Log accepted frames and writes; the cycle ceiling cuts a hang short
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (tx_valid_o === 1'b1 && tx_ready_i === 1'b1) begin
      got_q.push_back(tx_frame_o);
      at_q.push_back(cyc);
    end
    if (reg_wr_o === 1'b1) wr_q.push_back({reg_wr_addr_o, reg_wr_data_o});
    if (cyc == 40000) begin
      n_errors++;
      end_sim();
    end
  end

  task automatic cmp_val(input logic [47:0] exp, input logic [47:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : cmp_val

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim

  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask : tick

  task automatic put_entry(input logic [5:0] idx, input logic [15:0] ptr, input logic dir);
    entry_idx_i = idx;
    entry_source_pointer_i = ptr;
    entry_direction_select_i = dir;
    entry_wr_i = 1'b1;
    tick(1);
    entry_wr_i = 1'b0;
    tick(1);
  endtask : put_entry

  // Bounded wait for a number of accepted frames
  task automatic wait_frames(input int n);
    for (int i = 0; i < 9000 && got_q.size() < n; i++) tick(1);
  endtask : wait_frames

  initial begin
    int n;
    exp_f[0] = {RST_ID_ORIGIN, 16'hDA7A, 16'h0010};
    exp_f[1] = {RST_ID_ORIGIN + 11'h003, 16'hDA7A, 16'h0030};
    exp_f[2] = {RST_ID_ORIGIN + BLOCK_ID_OFFSET, 16'hDA7A, 16'h0100};
    exp_f[3] = {RST_ID_ORIGIN + BLOCK_ID_OFFSET + 11'h001, 16'hDA7A, 16'h0102};
    tick(6);
    cmp_val(8'h00, {tx_valid_o, reg_wr_o, reg_rd_req_o, scan_busy_o, conn_state_o});
    reset_n_i = 1'b1;
    // Connection state table, out-of-range codes included
    foreach (conn_row[i]) begin
      conn_state_i = conn_row[i][5:3];
      tick(2);
      cmp_val(conn_row[i][2:0], conn_state_o);
    end
    cfg_time_load_i = 1'b1;
    tick(1);
    cfg_time_load_i = 1'b0;
    // Reported, disabled, command, reported, disabled command; one block slot
    put_entry(6'h00, 16'h0010, 1'b0);
    put_entry(6'h01, PTR_DISABLED, 1'b0);
    put_entry(6'h02, 16'h0020, 1'b1);
    put_entry(6'h03, 16'h0030, 1'b0);
    put_entry(6'h04, PTR_DISABLED, 1'b1);
    slot_wr_i = 1'b1;
    tick(1);
    slot_wr_i = 1'b0;
    can_report_enable_i = 1'b1;
    wait_frames(8);
    cmp_val(report_period_i * CYC_PER_UNIT, at_q[4] - at_q[0]);
    cmp_val(1, (at_q[1] - at_q[0]) > CYC_PER_UNIT);
    // Far side now stalls every frame
    slow = 1'b1;
    wait_frames(12);
    cmp_val(12, got_q.size());
    foreach (got_q[i]) cmp_val(exp_f[i % 4], got_q[i]);
    // Command, reported and disabled ids back to back
    rx_frame_i = {RST_ID_ORIGIN + 11'h002, 32'h12345678};
    rx_valid_i = 1'b1;
    tick(1);
    rx_frame_i.id = RST_ID_ORIGIN;
    tick(1);
    rx_frame_i.id = RST_ID_ORIGIN + 11'h004;
    tick(1);
    rx_valid_i = 1'b0;
    tick(3);
    cmp_val(1, wr_q.size());
    cmp_val({16'h0020, 32'h12345678}, wr_q[0]);
    can_report_enable_i = 1'b0;
    tick(3000);
    n = got_q.size();
    tick(3000);
    cmp_val(n, got_q.size());
    // One error each 100 cycles gives ten per window
    repeat (40) begin
      bus_err_i = 1'b1;
      tick(1);
      bus_err_i = 1'b0;
      tick(99);
    end
    cmp_val(24'h00000A, err_rate_o);
    end_sim();
  end
endmodule : testbench

bind pcrr_top pcrr_chk chk_u (.*);
